//--- src/rxcp_top.v
// Purpose: Receiver configuration registers and start-pattern recognition.
// Assumes: Avalon-MM slave, 8-bit word address, one register per word.
// Notes:   Read of the status register clears it; the write-1 clear also works.
// Summary of operation
// - An 8-bit read/write signal threshold register resets to zero and sets the detect level.
// - Bits 7..4 of the filter register hold the low-pass bandwidth code.
// - Bits 3..0 of the filter register hold the channel filter code, reset 0011, sent to the filter.
// - Bits 7..4 of the polyphase register hold the centre code, reset 0011.
// - Bit 3 of the polyphase register enables amplifier step regulation.
// - Bit 7 of the recovery register enables the polyphase filter.
// - Bit 6 of the recovery register turns data and clock recovery off when set.
// - Bit 5 of the recovery register enables start-pattern recognition while bit 6 is clear.
// - Bits 4..3 of the recovery register pick one to four pattern bytes from the first byte on.
// - Bits 2..1 of the recovery register give zero to three tolerated bit errors.
// - The three receiver registers reset to a3, 38 and 18.
// - A sticky signal-detect flag sets when the level reaches the threshold and clears on write 1.
// - The first pattern byte is most significant and matched first.
// - A pattern match sets a sticky flag cleared by writing 1.
//
// Local design decision: the Avalon-MM interface to the registers.
`include "rxcp_consts.vh"
`default_nettype none

module rxcp_top (
  input  wire                      clk_i,
  input  wire                      rstn_i,
  input  wire [`RXCP_ADDR_W-1:0]   avs_address_i,
  input  wire                      avs_read_i,
  input  wire                      avs_write_i,
  input  wire [31:0]               avs_writedata_i,
  input  wire [3:0]                avs_byteenable_i,
  output reg  [31:0]               avs_readdata_o,
  output reg                       avs_waitrequest_o,
  input  wire [7:0]                signal_level_i,
  input  wire                      rx_bit_i,
  input  wire                      rx_bit_valid_i,
  output reg  [3:0]                lowpass_bandwidth_code_o,
  output reg  [3:0]                channel_filter_code_o,
  output reg  [3:0]                polyphase_centre_code_o,
  output reg                       amp_step_regulation_o,
  output reg                       polyphase_enable_o,
  output reg                       recovery_disable_o,
  output reg                       pattern_found_o,
  output reg                       irq_o
);

  // ==========================================================================
  // Input synchronisers
  reg  [7:0] level_s1_q;
  reg  [7:0] level_s2_q;
  reg  [7:0] level_s3_q;
  reg  [7:0] level_q;
  reg        bit_s1_q;
  reg        bit_s2_q;
  reg        valid_s1_q;
  reg        valid_s2_q;
  reg        valid_s3_q;
  wire       bit_strobe;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_s1_q <= 8'h00;
      level_s2_q <= 8'h00;
      level_s3_q <= 8'h00;
      level_q    <= 8'h00;
      bit_s1_q   <= 1'b0;
      bit_s2_q   <= 1'b0;
      valid_s1_q <= 1'b0;
      valid_s2_q <= 1'b0;
      valid_s3_q <= 1'b0;
    end else begin
      level_s1_q <= signal_level_i;
      level_s2_q <= level_s1_q;
      level_s3_q <= level_s2_q;
      // A level still moving between two samples is held back, so a torn word is never compared.
      if (level_s2_q == level_s3_q) begin
        level_q <= level_s2_q;
      end
      bit_s1_q   <= rx_bit_i;
      bit_s2_q   <= bit_s1_q;
      valid_s1_q <= rx_bit_valid_i;
      valid_s2_q <= valid_s1_q;
      valid_s3_q <= valid_s2_q;
    end
  end

  // A bit is taken on the rising edge of the synchronised valid level.
  assign bit_strobe = valid_s2_q & ~valid_s3_q;

  // ==========================================================================
  // Registers
  reg  [7:0]                threshold_q;
  reg  [7:0]                filter_q;
  reg  [7:0]                poly_amp_q;
  reg  [7:0]                recovery_q;
  reg  [7:0]                pat_q [0:3];
  reg  [`RXCP_FLAGS_W-1:0]  status_q;
  reg  [`RXCP_FLAGS_W-1:0]  mask_q;
  reg                       pending_q;
  reg                       match_armed;
  wire                      wr_strobe;
  wire                      rd_strobe;
  wire [7:0]                wbyte;
  wire                      signal_event;
  wire                      match_pulse;
  wire [`RXCP_FLAGS_W-1:0]  events;
  wire [`RXCP_FLAGS_W-1:0]  wr_clear;
  wire [`RXCP_FLAGS_W-1:0]  rd_clear;
  wire [`RXCP_FLAGS_W-1:0]  status_d;
  reg  [31:0]               rdata;

  function is_addr;
    input [`RXCP_ADDR_W-1:0] a;
    input [`RXCP_ADDR_W-1:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  // Waitrequest is high on the first cycle of each request, so every access takes two cycles.
  assign wr_strobe = avs_write_i & ~avs_waitrequest_o & pending_q;
  assign rd_strobe = avs_read_i & ~avs_waitrequest_o & pending_q;
  assign wbyte     = avs_writedata_i[7:0];

  assign signal_event = (level_q >= threshold_q);
  assign events       = {match_pulse, signal_event};
  assign wr_clear     = (wr_strobe && avs_byteenable_i[0] && is_addr(avs_address_i, `RXCP_OFF_STATUS)) ?
                        wbyte[`RXCP_FLAGS_W-1:0] : {`RXCP_FLAGS_W{1'b0}};
  // A read clears only the flags that it reported, so a flag set while the read waits is kept.
  assign rd_clear     = (rd_strobe && is_addr(avs_address_i, `RXCP_OFF_STATUS)) ?
                        avs_readdata_o[`RXCP_FLAGS_W-1:0] : {`RXCP_FLAGS_W{1'b0}};
  // A new event wins over a clear in the same cycle.
  assign status_d     = (status_q & ~(wr_clear | rd_clear)) | events;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_waitrequest_o <= 1'b1;
      pending_q         <= 1'b0;
    end else begin
      pending_q         <= (avs_read_i | avs_write_i) & avs_waitrequest_o;
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pat
      localparam integer PAT_OFF = `RXCP_OFF_PAT0 + g;
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          pat_q[g] <= `RXCP_RST_PAT;
        end else if (wr_strobe && avs_byteenable_i[0] &&
                     is_addr(avs_address_i, PAT_OFF[`RXCP_ADDR_W-1:0])) begin
          pat_q[g] <= wbyte;
        end
      end
    end
  endgenerate

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      threshold_q <= `RXCP_RST_THRESHOLD;
      filter_q    <= `RXCP_RST_FILTER;
      poly_amp_q  <= `RXCP_RST_POLY_AMP;
      recovery_q  <= `RXCP_RST_RECOVERY;
      mask_q      <= `RXCP_RST_FLAGS;
      status_q    <= `RXCP_RST_FLAGS;
    end else begin
      status_q <= status_d;
      if (wr_strobe && avs_byteenable_i[0]) begin
        if (is_addr(avs_address_i, `RXCP_OFF_THRESHOLD)) begin
          threshold_q <= wbyte;
        end
        if (is_addr(avs_address_i, `RXCP_OFF_FILTER)) begin
          filter_q <= wbyte;
        end
        if (is_addr(avs_address_i, `RXCP_OFF_POLY_AMP)) begin
          poly_amp_q <= (wbyte & `RXCP_POLY_AMP_WMASK) | (`RXCP_RST_POLY_AMP & ~`RXCP_POLY_AMP_WMASK);
        end
        if (is_addr(avs_address_i, `RXCP_OFF_RECOVERY)) begin
          recovery_q <= (wbyte & `RXCP_RECOVERY_WMASK) | (`RXCP_RST_RECOVERY & ~`RXCP_RECOVERY_WMASK);
        end
        if (is_addr(avs_address_i, `RXCP_OFF_MASK)) begin
          mask_q <= wbyte[`RXCP_FLAGS_W-1:0];
        end
      end
    end
  end

  // ==========================================================================
  // Read path
  always @* begin
    rdata = 32'h00000000;
    case (avs_address_i)
      `RXCP_OFF_THRESHOLD: rdata[7:0] = threshold_q;
      `RXCP_OFF_FILTER:    rdata[7:0] = filter_q;
      `RXCP_OFF_POLY_AMP:  rdata[7:0] = poly_amp_q;
      `RXCP_OFF_RECOVERY:  rdata[7:0] = recovery_q;
      `RXCP_OFF_PAT0:      rdata[7:0] = pat_q[0];
      `RXCP_OFF_PAT1:      rdata[7:0] = pat_q[1];
      `RXCP_OFF_PAT2:      rdata[7:0] = pat_q[2];
      `RXCP_OFF_PAT3:      rdata[7:0] = pat_q[3];
      `RXCP_OFF_STATUS:    rdata[`RXCP_FLAGS_W-1:0] = status_q;
      `RXCP_OFF_MASK:      rdata[`RXCP_FLAGS_W-1:0] = mask_q;
      `RXCP_OFF_LEVEL:     rdata[7:0] = level_q;
      default:             rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rdata;
    end
  end

  // ==========================================================================
  // Configuration outputs
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lowpass_bandwidth_code_o <= 4'h0;
      channel_filter_code_o    <= 4'h0;
      polyphase_centre_code_o  <= 4'h0;
      amp_step_regulation_o    <= 1'b0;
      polyphase_enable_o       <= 1'b0;
      recovery_disable_o       <= 1'b0;
      pattern_found_o          <= 1'b0;
      irq_o                    <= 1'b0;
      match_armed              <= 1'b0;
    end else begin
      lowpass_bandwidth_code_o <= filter_q[7:4];
      channel_filter_code_o    <= filter_q[3:0];
      polyphase_centre_code_o  <= poly_amp_q[7:4];
      amp_step_regulation_o    <= poly_amp_q[3];
      polyphase_enable_o       <= recovery_q[`RXCP_BIT_POLY_EN];
      recovery_disable_o       <= recovery_q[`RXCP_BIT_REC_DIS];
      pattern_found_o          <= status_d[`RXCP_FLAG_PATTERN];
      irq_o                    <= |(status_d & mask_q);
      match_armed              <= recovery_q[`RXCP_BIT_RECOG] & ~recovery_q[`RXCP_BIT_REC_DIS];
    end
  end

  // ==========================================================================
  // Start-pattern matcher
  rxcp_matcher u_matcher (
    .clk_i            (clk_i),
    .rstn_i           (rstn_i),
    .enable_i         (match_armed),
    .bit_i            (bit_s2_q),
    .bit_valid_i      (bit_strobe),
    .pattern_length_i (recovery_q[`RXCP_LEN_HI:`RXCP_LEN_LO]),
    .tolerance_i      (recovery_q[`RXCP_TOL_HI:`RXCP_TOL_LO]),
    .pattern_i        ({pat_q[0], pat_q[1], pat_q[2], pat_q[3]}),
    .match_o          (match_pulse)
  );

endmodule

`default_nettype wire

//--- src/rxcp_consts.vh
// Purpose: Constants for the receiver configuration and start-pattern match block.
// Assumes: Included by every design file of the block.
// Notes:   Word addresses on the Avalon bus are the printed offsets.
`ifndef RXCP_CONSTS_VH
`define RXCP_CONSTS_VH

// ==========================================================================
// Register offsets
`define RXCP_ADDR_W          8
`define RXCP_OFF_THRESHOLD   8'h0f
`define RXCP_OFF_FILTER      8'h10
`define RXCP_OFF_POLY_AMP    8'h11
`define RXCP_OFF_RECOVERY    8'h12
`define RXCP_OFF_PAT0        8'h16
`define RXCP_OFF_PAT1        8'h17
`define RXCP_OFF_PAT2        8'h18
`define RXCP_OFF_PAT3        8'h19
`define RXCP_OFF_STATUS      8'h20
`define RXCP_OFF_MASK        8'h21
`define RXCP_OFF_LEVEL       8'h22

// ==========================================================================
// Reset values
`define RXCP_RST_THRESHOLD   8'h00
`define RXCP_RST_FILTER      8'ha3
`define RXCP_RST_POLY_AMP    8'h38
`define RXCP_RST_RECOVERY    8'h18
`define RXCP_RST_PAT         8'h00
`define RXCP_RST_FLAGS       2'h0

// ==========================================================================
// Field layout
`define RXCP_POLY_AMP_WMASK  8'hf8
`define RXCP_RECOVERY_WMASK  8'hfe
`define RXCP_BIT_POLY_EN     7
`define RXCP_BIT_REC_DIS     6
`define RXCP_BIT_RECOG       5
`define RXCP_LEN_HI          4
`define RXCP_LEN_LO          3
`define RXCP_TOL_HI          2
`define RXCP_TOL_LO          1
`define RXCP_FLAG_SIGNAL     0
`define RXCP_FLAG_PATTERN    1
`define RXCP_FLAGS_W         2

// ==========================================================================
// Matcher
`define RXCP_PAT_W           32
`define RXCP_CNT_W           6
`define RXCP_LEN_1           2'h0
`define RXCP_LEN_2           2'h1
`define RXCP_LEN_3           2'h2
`define RXCP_MASK_1          32'h000000ff
`define RXCP_MASK_2          32'h0000ffff
`define RXCP_MASK_3          32'h00ffffff
`define RXCP_MASK_4          32'hffffffff

`endif

//--- src/rxcp_matcher.v
// Purpose: Start-pattern matcher on the recovered bit stream.
// Assumes: bit_valid_i is a one-cycle strobe on clk_i; inputs are synchronous.
// Notes:   A match is a one-cycle pulse; the first pattern byte is matched first.
`include "rxcp_consts.vh"
`default_nettype none

module rxcp_matcher (
  input  wire                      clk_i,
  input  wire                      rstn_i,
  input  wire                      enable_i,
  input  wire                      bit_i,
  input  wire                      bit_valid_i,
  input  wire [1:0]                pattern_length_i,
  input  wire [1:0]                tolerance_i,
  input  wire [`RXCP_PAT_W-1:0]    pattern_i,
  output reg                       match_o
);

  reg  [`RXCP_PAT_W-1:0] shift_q;
  reg  [`RXCP_PAT_W-1:0] sel_mask;
  reg  [`RXCP_PAT_W-1:0] aligned;
  reg  [`RXCP_CNT_W-1:0] errors;
  wire [`RXCP_PAT_W-1:0] window;
  integer                i;

  // The bit arriving with the strobe belongs to the window, so the last pattern bit completes a match.
  assign window = {shift_q[`RXCP_PAT_W-2:0], bit_i};

  // ==========================================================================
  // Pattern alignment
  // The first pattern byte sits at the top of the pattern word, so a short
  // pattern is shifted down until its first byte is the oldest received.
  always @* begin
    case (pattern_length_i)
      `RXCP_LEN_1: begin
        sel_mask = `RXCP_MASK_1;
        aligned  = pattern_i >> 24;
      end
      `RXCP_LEN_2: begin
        sel_mask = `RXCP_MASK_2;
        aligned  = pattern_i >> 16;
      end
      `RXCP_LEN_3: begin
        sel_mask = `RXCP_MASK_3;
        aligned  = pattern_i >> 8;
      end
      default: begin
        sel_mask = `RXCP_MASK_4;
        aligned  = pattern_i;
      end
    endcase
  end

  // ==========================================================================
  // Mismatch count
  always @* begin
    errors = {`RXCP_CNT_W{1'b0}};
    for (i = 0; i < `RXCP_PAT_W; i = i + 1) begin
      errors = errors + {{(`RXCP_CNT_W-1){1'b0}}, sel_mask[i] & (window[i] ^ aligned[i])};
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_q <= {`RXCP_PAT_W{1'b0}};
      match_o <= 1'b0;
    end else begin
      match_o <= 1'b0;
      if (bit_valid_i) begin
        shift_q <= window;
      end
      if (enable_i && bit_valid_i) begin
        match_o <= (errors <= {{(`RXCP_CNT_W-2){1'b0}}, tolerance_i});
      end
    end
  end

endmodule

`default_nettype wire

//--- bench/rxcp_top_chk.sv
// Purpose: Assertions on the bus handshake and configuration outputs of rxcp_top.
// Assumes: Sees only the ports of rxcp_top; one clock domain.
// Notes:   Attached by the bind statement after the module.
`default_nettype none
module rxcp_top_chk (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [3:0]  lowpass_bandwidth_code_o,
  input wire logic [3:0]  channel_filter_code_o,
  input wire logic [3:0]  polyphase_centre_code_o,
  input wire logic        amp_step_regulation_o,
  input wire logic        polyphase_enable_o,
  input wire logic        recovery_disable_o,
  input wire logic        pattern_found_o
);
  logic status_acc;
  assign status_acc = (avs_read_i || avs_write_i) && !avs_waitrequest_o && avs_address_i == 8'h20;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence wr_done(a);
    avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i == a;
  endsequence
  sequence rd_done(a);
    avs_read_i && !avs_waitrequest_o && avs_address_i == a;
  endsequence
  // ==========================================================================
  // Bus handshake and register effects
  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest not low one cycle after a request");
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  filt_write_a: assert property (wr_done(8'h10) |-> ##2
    {lowpass_bandwidth_code_o, channel_filter_code_o} == $past(avs_writedata_i[7:0], 2))
    else $error("filter codes do not follow the write");
  poly_write_a: assert property (wr_done(8'h11) |-> ##2
    {polyphase_centre_code_o, amp_step_regulation_o} == $past(avs_writedata_i[7:3], 2))
    else $error("polyphase fields do not follow the write");
  rec_write_a: assert property (wr_done(8'h12) |-> ##2
    {polyphase_enable_o, recovery_disable_o} == $past(avs_writedata_i[7:6], 2))
    else $error("recovery fields do not follow the write");
  unmapped_read_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 8'h22 |-> avs_readdata_o == 0)
    else $error("unmapped read not zero");
  resv_poly_a: assert property (rd_done(8'h11) |-> avs_readdata_o[2:0] == 3'h0)
    else $error("unused polyphase bits not zero");
  resv_rec_a: assert property (rd_done(8'h12) |-> avs_readdata_o[0] == 1'b0)
    else $error("unused recovery bit not zero");
  found_clear_a: assert property ($fell(pattern_found_o) |-> $past(status_acc) || $past(status_acc, 2))
    else $error("pattern flag dropped without a status access");
endmodule
bind rxcp_top rxcp_top_chk i_chk (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .lowpass_bandwidth_code_o(lowpass_bandwidth_code_o), .channel_filter_code_o(channel_filter_code_o),
  .polyphase_centre_code_o(polyphase_centre_code_o), .amp_step_regulation_o(amp_step_regulation_o),
  .polyphase_enable_o(polyphase_enable_o), .recovery_disable_o(recovery_disable_o),
  .pattern_found_o(pattern_found_o));
`default_nettype wire

//--- bench/rx_config_and_pattern_match_test.sv
// Purpose: Self-checking bench for rxcp_top.
// Assumes: One clock; each bus access takes one wait cycle.
// Notes:   Random data from a fixed seed.
`default_nettype none
module rx_config_and_pattern_match_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rstn_i = 0, avs_read_i = 0, avs_write_i = 0, rx_bit_i = 0, rx_bit_valid_i = 0;
  logic [7:0]  avs_address_i = 0, signal_level_i = 0, rdq, a, d;
  logic [31:0] avs_writedata_i = 0, avs_readdata_o, pat, s;
  logic [3:0]  avs_byteenable_i = 0, lp, cf, pc;
  logic        avs_waitrequest_o, amp, pen, rdis, found, irq, ex;
  int          n_mismatch = 0, total_checks = 0, cyc = 0, ln, tol, e, n;
  rxcp_top i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .signal_level_i(signal_level_i),
    .rx_bit_i(rx_bit_i), .rx_bit_valid_i(rx_bit_valid_i), .lowpass_bandwidth_code_o(lp),
    .channel_filter_code_o(cf), .polyphase_centre_code_o(pc), .amp_step_regulation_o(amp),
    .polyphase_enable_o(pen), .recovery_disable_o(rdis), .pattern_found_o(found), .irq_o(irq));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic rd, input logic [7:0] ad, input logic [7:0] wd, input logic be);
    avs_address_i <= ad;
    avs_writedata_i <= {24'h0, wd};
    avs_byteenable_i <= {3'h0, be};
    avs_read_i <= rd;
    avs_write_i <= !rd;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    rdq = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
    bus(1'b1, ad, 8'h00, 1'b1);
    chk(rdq, exp);
  endtask
  // Sends bits v[cnt-1:0], oldest first, each with one valid rise.
  task automatic send(input logic [31:0] v, input int cnt);
    for (int k = cnt - 1; k >= 0; k--) begin
      rx_bit_i <= v[k];
      repeat (2) @(posedge clk_i);
      rx_bit_valid_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rx_bit_valid_i <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask
  function automatic logic [7:0] rb(input logic [7:0] ad, input logic [7:0] wd);
    return (ad == 8'h11) ? (wd & 8'hf8) : (ad == 8'h12) ? (wd & 8'hfe) : wd;
  endfunction
  initial begin
    void'($urandom(32'h5c7759ca));
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd_chk(8'h0f, 8'h00);
    rd_chk(8'h10, 8'ha3);
    rd_chk(8'h11, 8'h38);
    rd_chk(8'h12, 8'h18);
    rd_chk(8'h16, 8'h00);
    rd_chk(8'h30, 8'h00);
    chk({lp, cf}, 8'ha3);
    chk({pc, amp, 3'h0}, 8'h38);
    chk({pen, rdis, 6'h0}, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      a = 8'h0f + 8'(i % 4);
      d = (i < 4) ? 8'hff : (i < 8) ? 8'h00 : 8'($urandom);
      if (a == 8'h12 && cf > 4'h1) d[7] = 1'b0;
      bus(1'b0, a, d, 1'b1);
      bus(1'b0, a, ~d, 1'b0);
      rd_chk(a, rb(a, d));
      if (a == 8'h10) chk({lp, cf}, d);
      if (a == 8'h11) chk({pc, amp, 3'h0}, d & 8'hf8);
      if (a == 8'h12) chk({pen, rdis, 6'h0}, d & 8'hc0);
    end
    $display("test register access done");
    bus(1'b0, 8'h0f, 8'h80, 1'b1);
    bus(1'b0, 8'h21, 8'h01, 1'b1);
    rd_chk(8'h21, 8'h01);
    bus(1'b0, 8'h20, 8'h03, 1'b1);
    rd_chk(8'h20, 8'h00);
    chk({7'h0, irq}, 8'h00);
    signal_level_i <= 8'h80;
    repeat (6) @(posedge clk_i);
    chk({7'h0, irq}, 8'h01);
    rd_chk(8'h22, 8'h80);
    signal_level_i <= 8'h7f;
    repeat (6) @(posedge clk_i);
    rd_chk(8'h20, 8'h01);
    rd_chk(8'h20, 8'h00);
    bus(1'b0, 8'h21, 8'h00, 1'b1);
    signal_level_i <= 8'hf0;
    repeat (6) @(posedge clk_i);
    chk({7'h0, irq}, 8'h00);
    signal_level_i <= 8'h00;
    $display("test signal detect done");
    bus(1'b0, 8'h21, 8'h02, 1'b1);
    for (int i = 0; i < 12; i++) begin
      pat = $urandom;
      for (int b = 0; b < 4; b++) bus(1'b0, 8'h16 + 8'(b), pat[31 - 8 * b -: 8], 1'b1);
      ln = i % 4;
      tol = (i + i / 4) % 4;
      e = $urandom % 4;
      bus(1'b0, 8'h12, {1'b0, i == 11, i != 10, 2'(ln), 2'(tol), 1'b0}, 1'b1);
      n = 8 * (ln + 1);
      s = (pat >> (32 - n)) ^ ((32'h1 << e) - 32'h1);
      send(s >> 1, n - 1);
      bus(1'b1, 8'h20, 8'h00, 1'b1);
      send(s, 1);
      ex = (e <= tol) && i < 10;
      chk({7'h0, found}, {7'h0, ex});
      repeat (10) @(posedge clk_i);
      chk({7'h0, irq}, {7'h0, ex});
    end
    $display("test pattern match done");
    end_sim();
  end
endmodule
`default_nettype wire
